// file: epvu_pkg.sv
// constants for the exception priority and vector unit
// assumes a 16-bit address map with vectors in the top 128 bytes
package epvu_pkg;

  // maskable slots: 18 evenly spaced vectors, then two extra sources
  localparam int NUM_SLOTS = 20;
  localparam int NUM_EVEN_SLOTS = 18;
  localparam logic [4:0] SLOT_MODULUS = 5'h12;
  localparam logic [4:0] SLOT_PULSE_ACC2 = 5'h13;
  localparam logic [4:0] SLOT_NONE = 5'h1f;

  // vector table base: all vectors lie at or above this address
  localparam logic [15:0] VEC_TABLE_BASE = 16'hff80;

  // non-maskable vectors
  localparam logic [15:0] VEC_RESET = 16'hfffe;
  localparam logic [15:0] VEC_CLOCK_MON = 16'hfffc;
  localparam logic [15:0] VEC_WATCHDOG = 16'hfffa;
  localparam logic [15:0] VEC_TRAP = 16'hfff8;
  localparam logic [15:0] VEC_SWI = 16'hfff6;
  localparam logic [15:0] VEC_NMI_PIN = 16'hfff4;

  // maskable vectors
  localparam logic [15:0] VEC_MASK_TOP = 16'hfff2;
  localparam logic [15:0] VEC_MASK_STEP = 16'h0002;
  localparam logic [15:0] VEC_MODULUS = 16'hffcc;
  localparam logic [15:0] VEC_PULSE_ACC2 = 16'hffca;

  // second byte of a vector pair sits one address above the first
  localparam logic [15:0] VEC_BYTE_STEP = 16'h0001;

  // reset values
  localparam logic [7:0] PRIO_RESET = 8'hf2;
  localparam logic CCR_I_RESET = 1'b1;
  localparam logic CCR_X_RESET = 1'b1;
  localparam logic [2:0] SYNC_RESET = 3'h7;

  // class of the source that won the last vector fetch
  typedef enum logic [2:0] {
    EPVU_WIN_RESET = 3'b000,
    EPVU_WIN_CLOCK_MON = 3'b001,
    EPVU_WIN_WATCHDOG = 3'b010,
    EPVU_WIN_TRAP = 3'b011,
    EPVU_WIN_SWI = 3'b100,
    EPVU_WIN_NMI_PIN = 3'b101,
    EPVU_WIN_MASKABLE = 3'b110,
    EPVU_WIN_SPURIOUS = 3'b111
  } epvu_win_e;

endpackage : epvu_pkg

// file: epvu_exception_priority.sv
// exception priority arbiter and vector generator
// assumes all requesters except the two pins run on core_clk_in;
// the cpu pulses vec_req_in once interrupt processing has begun
// Operation
// - each source has own vector in top 128 bytes
// - six top slots non-maskable, rest maskable
// - fixed order reset, clock monitor, watchdog, trap, swi, pin
// - nonmaskable pin accepted only while x bit clear
// - maskable requests only while i bit clear
// - i bit resets to one, writable anytime
// - one maskable source promotable to top priority
// - promoted source still obeys i bit, local enable
// - promotion never changes any vector address
// - priority select writes only while i bit set
// - default maskable order is descending vector address
// - non-maskable vector addresses fffe down to fff4
// - serial peripheral vector ffd8, promote value d8
// - pulse accumulator edge vector ffda, promote da
// - second pulse accumulator overflow ffca, promote ca
// - modulus underflow vector ffcc, promote cc
// - high byte fetched from lower vector address
// - no active source at fetch gives trap vector
module epvu_exception_priority (
  input wire logic core_clk_in,
  input wire logic srst_in,
  input wire logic por_req_in,
  input wire logic clock_fail_in,
  input wire logic clock_monitor_enable_in,
  input wire logic forced_clock_monitor_enable_in,
  input wire logic watchdog_reset_in,
  input wire logic trap_req_in,
  input wire logic software_interrupt_instr_in,
  input wire logic nonmaskable_irq_pin_n_in,
  input wire logic ext_irq_pin_n_in,
  input wire logic external_irq_enable_in,
  input wire logic [18:0] periph_req_in,
  input wire logic [18:0] periph_en_in,
  input wire logic ccr_wr_in,
  input wire logic ccr_i_in,
  input wire logic ccr_x_in,
  input wire logic prio_wr_in,
  input wire logic [7:0] prio_data_in,
  input wire logic vec_req_in,
  output logic ccr_i_out,
  output logic ccr_x_out,
  output logic [7:0] priority_select_reg_out,
  output logic irq_pending_out,
  output logic vec_valid_out,
  output logic [15:0] vec_hi_addr_out,
  output logic [15:0] vec_lo_addr_out,
  output logic [2:0] vec_class_out,
  output logic [4:0] vec_slot_out
);

  typedef struct packed {
    logic [2:0] nmi_sync;
    logic [2:0] irq_sync;
    logic nmi_low;
    logic irq_low;
    logic ccr_i;
    logic ccr_x;
    logic [7:0] prio;
    logic pending;
    logic vec_valid;
    logic [15:0] vec_hi;
    logic [15:0] vec_lo;
    logic [2:0] vec_class;
    logic [4:0] vec_slot;
  } epvu_state_s;

  epvu_state_s st_q;
  epvu_state_s st_d;

  // maskable slot map, highest default priority first:
  //   slot 0 external pin, vector fff2
  //   slot 1 real-time tick, fff0
  //   slots 2 to 9 timer channels 0 to 7, ffee down to ffe0
  //   slot 10 timer overflow, ffde
  //   slot 11 pulse accumulator overflow, ffdc
  //   slot 12 pulse accumulator edge, ffda
  //   slot 13 serial peripheral, ffd8
  //   slot 14 serial comm, ffd6
  //   slot 15 spare pair, ffd4; still requestable and promotable
  //   slot 16 analog converter, ffd2
  //   slot 17 serial link controller, ffd0
  //   slot 18 modulus underflow, ffcc
  //   slot 19 second pulse accumulator overflow, ffca
  // the last two break the even spacing, so they are named apart
  // rather than stretching the arithmetic over a gap

  // vector of a maskable slot; fixed by slot, never by priority
  function automatic logic [15:0] epvu_slot_vec(input logic [4:0] slot);
    logic [15:0] v;
    v = epvu_pkg::VEC_MASK_TOP;
    if (slot == epvu_pkg::SLOT_MODULUS) begin
      v = epvu_pkg::VEC_MODULUS;
    end else if (slot == epvu_pkg::SLOT_PULSE_ACC2) begin
      v = epvu_pkg::VEC_PULSE_ACC2;
    end else begin
      v = 16'(epvu_pkg::VEC_MASK_TOP
        - 16'(slot) * epvu_pkg::VEC_MASK_STEP);
    end
    return v;
  endfunction : epvu_slot_vec

  // the low byte of a pair sits one address above the high byte
  function automatic logic [15:0] epvu_pair_lo(input logic [15:0] hi);
    return 16'(hi + epvu_pkg::VEC_BYTE_STEP);
  endfunction : epvu_pair_lo

  // true when the select value names this slot's pair; every vector
  // shares the high byte of the table base, so only the low byte is kept
  function automatic logic epvu_prio_match(input logic [4:0] slot,
      input logic [7:0] sel);
    logic [15:0] v;
    v = epvu_slot_vec(slot);
    return v >= epvu_pkg::VEC_TABLE_BASE
      && v == {epvu_pkg::VEC_TABLE_BASE[15:8], sel};
  endfunction : epvu_prio_match

  // request vectors indexed by slot; bit 0 is the synchronised pin
  logic [19:0] mask_raw;
  logic [19:0] mask_act;
  // promotion search result and the resulting maskable winner
  logic [4:0] promo_slot;
  logic promo_hit;
  logic [4:0] win_slot;
  // gated non-maskable terms that need more than a plain request
  logic clk_mon_act;
  logic nmi_act;
  logic mask_any;
  // winner of the whole chain, captured only on a fetch; any_act feeds pending every cycle
  logic [15:0] sel_vec;
  logic [2:0] sel_class;
  logic [4:0] sel_slot;
  logic any_act;

  always_comb begin
    st_d = st_q;
    // pins: stage 1 feeds only stage 2, so a metastable first stage never
    // reaches the decision; a level counts once stages 2 and 3 agree,
    // which also drops one-cycle glitches. the price is a few cycles of
    // latency between a pin change and the arbiter
    st_d.nmi_sync = {st_q.nmi_sync[1:0], nonmaskable_irq_pin_n_in};
    st_d.irq_sync = {st_q.irq_sync[1:0], ext_irq_pin_n_in};
    if (st_q.nmi_sync[1] == st_q.nmi_sync[2]) begin
      st_d.nmi_low = ~st_q.nmi_sync[2];
    end
    if (st_q.irq_sync[1] == st_q.irq_sync[2]) begin
      st_d.irq_low = ~st_q.irq_sync[2];
    end

    // slot 0 is the external pin; the rest are peripheral flags.
    // the i bit gates the whole set with one term, so a promoted slot
    // passes the very same gate as any other and cannot bypass the mask
    mask_raw = {periph_req_in & periph_en_in,
      st_q.irq_low & external_irq_enable_in};
    mask_act = st_q.ccr_i ? 20'h00000 : mask_raw;

    // find the slot whose vector low byte matches the select value.
    // a value that names no pair finds nothing and leaves the default
    // order alone; the reset value names slot 0, which is already first,
    // so reset and default order agree
    promo_slot = epvu_pkg::SLOT_NONE;
    promo_hit = 1'b0;
    for (int k = 0; k < epvu_pkg::NUM_SLOTS; k++) begin
      if (epvu_prio_match(5'(k), st_q.prio)) begin
        promo_slot = 5'(k);
        promo_hit = 1'b1;
      end
    end

    // default order: lowest slot index is highest priority; the loop
    // runs downwards so the last hit is the lowest active slot, and the
    // promoted slot then overrides it only if it is itself active
    win_slot = epvu_pkg::SLOT_NONE;
    for (int k = epvu_pkg::NUM_SLOTS - 1; k >= 0; k--) begin
      if (mask_act[k]) begin
        win_slot = 5'(k);
      end
    end
    if (promo_hit && mask_act[promo_slot]) begin
      win_slot = promo_slot;
    end
    mask_any = |mask_act;

    clk_mon_act = clock_fail_in
      & (clock_monitor_enable_in | forced_clock_monitor_enable_in);
    nmi_act = st_q.nmi_low & ~st_q.ccr_x;

    // non-maskable chain ahead of any maskable winner. the chain is a
    // plain if ladder on purpose: its order is the priority, and the
    // maskable winner only ever enters at the bottom, so no select value
    // can lift a maskable source above a reset, trap or pin request.
    // only the pin is gated by x; the others are always accepted, except the clock monitor, which needs one of its two enables
    sel_slot = epvu_pkg::SLOT_NONE;
    any_act = 1'b1;
    if (por_req_in) begin
      sel_vec = epvu_pkg::VEC_RESET;
      sel_class = epvu_pkg::EPVU_WIN_RESET;
    end else if (clk_mon_act) begin
      sel_vec = epvu_pkg::VEC_CLOCK_MON;
      sel_class = epvu_pkg::EPVU_WIN_CLOCK_MON;
    end else if (watchdog_reset_in) begin
      sel_vec = epvu_pkg::VEC_WATCHDOG;
      sel_class = epvu_pkg::EPVU_WIN_WATCHDOG;
    end else if (trap_req_in) begin
      sel_vec = epvu_pkg::VEC_TRAP;
      sel_class = epvu_pkg::EPVU_WIN_TRAP;
    end else if (software_interrupt_instr_in) begin
      sel_vec = epvu_pkg::VEC_SWI;
      sel_class = epvu_pkg::EPVU_WIN_SWI;
    end else if (nmi_act) begin
      sel_vec = epvu_pkg::VEC_NMI_PIN;
      sel_class = epvu_pkg::EPVU_WIN_NMI_PIN;
    end else if (mask_any) begin
      sel_vec = epvu_slot_vec(win_slot);
      sel_class = epvu_pkg::EPVU_WIN_MASKABLE;
      sel_slot = win_slot;
    end else begin
      // source vanished after processing began; the cpu still needs an
      // address, and the trap handler is the one place that can cope
      // with a request that withdrew itself
      sel_vec = epvu_pkg::VEC_TRAP;
      sel_class = epvu_pkg::EPVU_WIN_SPURIOUS;
      any_act = 1'b0;
    end

    // pending is only a hint: the decision that counts is taken again
    // at the fetch edge, so a source that drops in between is harmless.
    // address, class and slot hold between fetches so the cpu may read
    // both bytes of the pair at its own pace
    st_d.pending = any_act;
    st_d.vec_valid = vec_req_in;
    if (vec_req_in) begin
      st_d.vec_hi = sel_vec;
      st_d.vec_lo = epvu_pair_lo(sel_vec);
      st_d.vec_class = sel_class;
      st_d.vec_slot = sel_slot;
    end

    // select write uses the mask as it stands before a same-cycle ccr
    // write; a write that clears i and moves the select in one cycle is
    // therefore still accepted, since software had interrupts inhibited
    // when it issued both
    if (prio_wr_in && st_q.ccr_i) begin
      st_d.prio = prio_data_in;
    end
    if (ccr_wr_in) begin
      st_d.ccr_i = ccr_i_in;
      st_d.ccr_x = ccr_x_in;
    end

    // reset last so it overrides every update above; the pin stages
    // start at their idle high level so no false request follows reset
    if (srst_in) begin
      st_d = '0;
      st_d.nmi_sync = epvu_pkg::SYNC_RESET;
      st_d.irq_sync = epvu_pkg::SYNC_RESET;
      st_d.ccr_i = epvu_pkg::CCR_I_RESET;
      st_d.ccr_x = epvu_pkg::CCR_X_RESET;
      st_d.prio = epvu_pkg::PRIO_RESET;
      st_d.vec_hi = epvu_pkg::VEC_RESET;
      st_d.vec_lo = epvu_pair_lo(epvu_pkg::VEC_RESET);
      st_d.vec_slot = epvu_pkg::SLOT_NONE;
    end
  end

  always_ff @(posedge core_clk_in) begin
    st_q <= st_d;
  end

  // every output is a field of the registered state, so nothing
  // combinational reaches a pin and the cpu sees settled values
  assign ccr_i_out = st_q.ccr_i;
  assign ccr_x_out = st_q.ccr_x;
  assign priority_select_reg_out = st_q.prio;
  assign irq_pending_out = st_q.pending;
  assign vec_valid_out = st_q.vec_valid;
  assign vec_hi_addr_out = st_q.vec_hi;
  assign vec_lo_addr_out = st_q.vec_lo;
  assign vec_class_out = st_q.vec_class;
  assign vec_slot_out = st_q.vec_slot;

endmodule : epvu_exception_priority

// file: epvu_irq_partner.sv
// pin-side model of the two interrupt pins of the vector unit
// assumes level requests from the bench; pins have pull-ups
module epvu_irq_partner (
  input wire logic nmi_req_in,
  input wire logic ext_req_in,
  output logic nmi_pin_n_out,
  output logic ext_pin_n_out
);
  timeunit 1ns;
  timeprecision 1ns;
  // a released open-drain pin goes to its pull-up level, never floats
  assign nmi_pin_n_out = nmi_req_in ? 1'b0 : 1'b1;
  assign ext_pin_n_out = ext_req_in ? 1'b0 : 1'b1;
endmodule : epvu_irq_partner

// file: epvu_exception_priority_assertions.sv
// port assertions for the exception priority unit
// assumes one clock domain and a synchronous active-high reset
module epvu_exception_priority_checker (
  input wire logic core_clk_in,
  input wire logic srst_in,
  input wire logic por_req_in,
  input wire logic software_interrupt_instr_in,
  input wire logic prio_wr_in,
  input wire logic [7:0] prio_data_in,
  input wire logic vec_req_in,
  input wire logic ccr_i_out,
  input wire logic [7:0] priority_select_reg_out,
  input wire logic vec_valid_out,
  input wire logic [15:0] vec_hi_addr_out,
  input wire logic [15:0] vec_lo_addr_out,
  input wire logic [2:0] vec_class_out
);
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (srst_in);
  a_vec_window: assert property (vec_valid_out |->
    vec_hi_addr_out >= 16'hff80 && !vec_hi_addr_out[0])
    else $error("vector outside table");
  a_byte_pair: assert property (vec_valid_out |->
    vec_lo_addr_out == vec_hi_addr_out + 16'h0001)
    else $error("vector byte pair broken");
  a_reset_first: assert property (vec_req_in && por_req_in |=>
    vec_valid_out && vec_hi_addr_out == 16'hfffe)
    else $error("reset vector not chosen");
  a_nonmask_wins: assert property (vec_valid_out &&
    vec_class_out == 3'h6 |->
    !$past(por_req_in) && !$past(software_interrupt_instr_in))
    else $error("maskable beat nonmaskable");
  a_mask_gate: assert property (vec_valid_out &&
    vec_class_out == 3'h6 |-> !$past(ccr_i_out))
    else $error("maskable taken while masked");
  a_spurious_trap: assert property (vec_valid_out &&
    vec_class_out == 3'h7 |-> vec_hi_addr_out == 16'hfff8)
    else $error("spurious fetch not trap vector");
  a_prio_locked: assert property (prio_wr_in && !ccr_i_out |=>
    $stable(priority_select_reg_out))
    else $error("select written while unmasked");
  a_prio_taken: assert property (prio_wr_in && ccr_i_out |=>
    priority_select_reg_out == $past(prio_data_in))
    else $error("select write lost");
  cover property (vec_valid_out && vec_class_out == 3'h6);
  cover property (vec_valid_out && vec_class_out == 3'h7);
  cover property (prio_wr_in && !ccr_i_out);
endmodule : epvu_exception_priority_checker
bind epvu_exception_priority epvu_exception_priority_checker u_chk (.*);

// file: test_exception_priority_vector_unit.sv
// self-checking bench for the exception priority unit
// assumes the pin partner drives both active-low interrupt pins
module test_exception_priority_vector_unit;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0, srst = 1'b1, vr = 1'b0, cw = 1'b0, ci = 1'b1;
  logic cx = 1'b1, pw = 1'b0, nmi_n, ext_n, i_o, x_o, vv, pend;
  logic [7:0] pd = 8'h00, sel;
  logic [5:0] nm = 6'h00;
  logic [1:0] cmen = 2'b10;
  logic [19:0] preq = '0, pen = '0;
  logic [15:0] hi, lo;
  logic [2:0] cls;
  logic [4:0] slot;
  int failures = 0, checks_done = 0;
  logic [7:0] pv [6] = '{8'hda, 8'hd8, 8'hca, 8'hcc, 8'h81, 8'hf2};
  logic [15:0] pe [6] = '{16'hffda, 16'hffd8, 16'hffca, 16'hffcc,
    16'hfff2, 16'hfff2};
  always #50 clk = ~clk;
  epvu_irq_partner PRT (.nmi_req_in(nm[5]), .ext_req_in(preq[0]),
    .nmi_pin_n_out(nmi_n), .ext_pin_n_out(ext_n));
  epvu_exception_priority DUT (.core_clk_in(clk), .srst_in(srst),
    .por_req_in(nm[0]), .clock_fail_in(nm[1]),
    .clock_monitor_enable_in(cmen[0]),
    .forced_clock_monitor_enable_in(cmen[1]), .watchdog_reset_in(nm[2]),
    .trap_req_in(nm[3]), .software_interrupt_instr_in(nm[4]),
    .nonmaskable_irq_pin_n_in(nmi_n), .ext_irq_pin_n_in(ext_n),
    .external_irq_enable_in(pen[0]), .periph_req_in(preq[19:1]),
    .periph_en_in(pen[19:1]), .ccr_wr_in(cw), .ccr_i_in(ci),
    .ccr_x_in(cx), .prio_wr_in(pw), .prio_data_in(pd), .vec_req_in(vr),
    .ccr_i_out(i_o), .ccr_x_out(x_o), .priority_select_reg_out(sel),
    .irq_pending_out(pend), .vec_valid_out(vv), .vec_hi_addr_out(hi),
    .vec_lo_addr_out(lo), .vec_class_out(cls), .vec_slot_out(slot));
  task automatic check(input string what, input logic [15:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // answer is registered on the same edge that takes the request
  task automatic fetch(input logic [15:0] exp, input logic [2:0] c);
    @(posedge clk) vr <= 1'b1;
    @(posedge clk) vr <= 1'b0;
    #1 check("valid", {15'h0, vv}, 16'h0001);
    check("vector", hi, exp);
    check("low byte", lo, exp + 16'h0001);
    check("class", {13'h0, cls}, {13'h0, c});
    check("pending", {15'h0, pend}, {15'h0, c != 3'h7});
  endtask : fetch
  task automatic condition_code_reg(input logic i, x);
    @(posedge clk) begin cw <= 1'b1; ci <= i; cx <= x; end
    @(posedge clk) cw <= 1'b0;
  endtask : condition_code_reg
  task automatic prio(input logic [7:0] d);
    @(posedge clk) begin pw <= 1'b1; pd <= d; end
    @(posedge clk) pw <= 1'b0;
  endtask : prio
  function automatic logic [15:0] mvec(input int j);
    return j == 18 ? 16'hffcc : j == 19 ? 16'hffca : 16'hfff2 - 16'(2 * j);
  endfunction : mvec
  task automatic print_verdict;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : print_verdict
  initial begin
    repeat (8) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk) #1;
    check("ibit", {15'h0, i_o}, 16'h0001);
    check("select", {8'h0, sel}, 16'h00f2);
    fetch(16'hfff8, 3'h7);
    condition_code_reg(1'b0, 1'b1);
    @(posedge clk) begin nm <= '1; preq <= '1; pen <= '1; end
    repeat (8) @(posedge clk);
    for (int k = 0; k < 5; k++) begin
      fetch(16'hfffe - 16'(2 * k), 3'(k));
      @(posedge clk) nm[k] <= 1'b0;
    end
    fetch(16'hfff2, 3'h6);
    condition_code_reg(1'b0, 1'b0);
    repeat (8) @(posedge clk);
    fetch(16'hfff4, 3'h5);
    @(posedge clk) nm[5] <= 1'b0;
    repeat (8) @(posedge clk);
    for (int j = 0; j < 20; j++) begin
      fetch(mvec(j), 3'h6);
      check("slot", {11'h0, slot}, 16'(j));
      @(posedge clk) preq[j] <= 1'b0;
      repeat (8) @(posedge clk);
    end
    @(posedge clk) preq <= '1;
    for (int n = 0; n < 6; n++) begin
      condition_code_reg(1'b1, 1'b0);
      prio(pv[n]);
      condition_code_reg(1'b0, 1'b0);
      prio(8'hd0);
      #1 check("select", {8'h0, sel}, {8'h0, pv[n]});
      fetch(pe[n], 3'h6);
    end
    condition_code_reg(1'b1, 1'b0);
    prio(8'hd8);
    condition_code_reg(1'b0, 1'b0);
    @(posedge clk) pen[13] <= 1'b0;
    fetch(16'hfff2, 3'h6);
    condition_code_reg(1'b1, 1'b0);
    fetch(16'hfff8, 3'h7);
    condition_code_reg(1'b0, 1'b0);
    @(posedge clk) srst <= 1'b1;
    repeat (2) @(posedge clk);
    #1 check("ibit", {15'h0, i_o}, 16'h0001);
    check("xbit", {15'h0, x_o}, 16'h0001);
    check("select", {8'h0, sel}, 16'h00f2);
    check("reset vector", hi, 16'hfffe);
    check("slot", {11'h0, slot}, 16'h001f);
    @(posedge clk) srst <= 1'b0;
    fetch(16'hfff8, 3'h7);
    print_verdict();
  end
endmodule : test_exception_priority_vector_unit
